/* logic/link_status_regs.sv */
// Our own choices: the strobed register port and the placing of the registers.
`timescale 1ns/100ps
//
// Contract
// - status cleared on warm or cold reset
// - overuse flag when credit hits minimum
// - underuse flag after idle limit at maximum
// - per-channel far-end credit available indication
// - overflow flag when full buffer receives data
// - missed flag when sequence jumps by two
// - sequence error otherwise, except first value
// - flag on 16-bit frame check failure
// - flag on 8-bit check or sequence error
// - indicate retransmission buffer empty
// - per-lane active indication
// - signal lost flag while lane active
// - expose error count, overflow flag when active
// - standby, lost words, remote flush flags
// - per-lane connection timeout flag
// - per-lane inverted polarity flag
// - symbol alignment achieved flag
// - cold reset flushes and zeroes counters
// - cold reset loads default settings
// - warm reset zeroes credits, lane numbers, inversion
//
module link_status_regs
    import link_status_pkg::*;
#(
    parameter int NUM_VC = 4,
    parameter int NUM_LANE = 4,
    parameter logic [31:0] IDLE_LIMIT = IDLE_CYCLES
) (
    // clock and resets
    input wire logic mclk_in,
    input wire logic reset_in,
    input wire logic cold_reset_in,
    input wire logic warm_reset_in,
    // register port
    input wire logic [7:0] addr_in,
    input wire logic [31:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [31:0] rdata_out,
    // layer reports
    input wire vc_report_type [NUM_VC-1:0] vc_in,
    input wire logic [SEQ_W-1:0] bc_seq_in,
    input wire logic bc_seq_valid_in,
    input wire logic crc16_err_in,
    input wire logic crc8_seq_err_in,
    input wire logic retry_empty_in,
    input wire logic retry_start_in,
    input wire lane_report_type [NUM_LANE-1:0] lane_in,
    input wire logic symbol_sync_in,
    // reset effects
    output logic cold_clear_out,
    output logic credit_zero_out,
    output logic pll_reset_out,
    // settings
    output logic [NUM_VC*PRIO_W-1:0] priority_out,
    output logic [NUM_VC*BW_W-1:0] bandwidth_out,
    output logic [NUM_VC*SLOT_W-1:0] slots_out,
    output logic [NUM_LANE-1:0] start_mode_out,
    output logic [NUM_LANE-1:0] autostart_out,
    output logic [NUM_LANE-1:0] bit_invert_out,
    output logic [3:0] required_lanes_out,
    output logic [31:0] seed_out,
    output logic [LNUM_W-1:0] dist_lane_out,
    output logic [LNUM_W-1:0] conc_lane_out
);
    localparam int VCW = NUM_VC * VC_BITS;
    localparam int LNW = NUM_LANE * LANE_BITS;

    wire any_reset = cold_reset_in | warm_reset_in;
    wire status_clr = any_reset;

    // address decode
    wire wr_vc = wr_in && addr_in == ADDR_VC_STAT;
    wire wr_bcq = wr_in && addr_in == ADDR_BCQ_STAT;
    wire wr_lane = wr_in && addr_in == ADDR_LANE_STAT;
    wire wr_prio = wr_in && addr_in == ADDR_PRIO;
    wire wr_bw = wr_in && addr_in == ADDR_BW;
    wire wr_slots = wr_in && addr_in == ADDR_SLOTS;
    wire wr_idle = wr_in && addr_in == ADDR_IDLE;
    wire wr_ctl = wr_in && addr_in == ADDR_LANE_CTL;
    wire wr_seed = wr_in && addr_in == ADDR_SEED;
    wire wr_lnum = wr_in && addr_in == ADDR_LANE_NUM;

    logic [VCW-1:0] vc_q;
    logic [VCW-1:0] vc_set;
    logic [VCW-1:0] vc_sticky;
    logic [VCW-1:0] vc_view;
    logic [BCQ_BITS-1:0] bcq_q;
    logic [BCQ_BITS-1:0] bcq_set;
    logic [BCQ_BITS-1:0] bcq_view;
    logic [LNW-1:0] lane_q;
    logic [LNW-1:0] lane_set;
    logic [LNW-1:0] lane_sticky;
    logic [LNW-1:0] lane_view;
    logic [NUM_LANE*RXERR_W-1:0] rxerr_view;
    logic [RETRY_W-1:0] retry_cnt_q;
    logic [SEQ_W-1:0] bc_last_q;
    logic bc_first_q;
    logic [31:0] idle_limit_q;
    logic [31:0] lane_ctl_view;

    // per channel flags
    genvar gi;
    generate
        for (gi = 0; gi < NUM_VC; gi++) begin : g_vc
            logic [31:0] idle_cnt_q;
            wire at_max = vc_in[gi].credit == CREDIT_MAX;
            wire idle_done = at_max && idle_cnt_q >= idle_limit_q;
            always_ff @(posedge mclk_in or posedge reset_in) begin
                if (reset_in) begin
                    idle_cnt_q <= '0;
                end else if (status_clr || !at_max) begin
                    idle_cnt_q <= '0;
                end else if (!idle_done) begin
                    idle_cnt_q <= idle_cnt_q + 32'h0000_0001;
                end
            end
            assign vc_set[gi*VC_BITS+VC_OVERUSE] =
                vc_in[gi].credit == CREDIT_MIN;
            assign vc_set[gi*VC_BITS+VC_UNDERUSE] = idle_done;
            assign vc_set[gi*VC_BITS+VC_CREDIT] = vc_in[gi].far_space;
            assign vc_set[gi*VC_BITS+VC_OVERFLOW] =
                vc_in[gi].write_when_full;
            // credit is a live level, the rest are sticky
            assign vc_sticky[gi*VC_BITS+:VC_BITS] = 4'hB;
        end
        for (gi = 0; gi < NUM_LANE; gi++) begin : g_lane
            wire act = lane_in[gi].active;
            assign lane_set[gi*LANE_BITS+:LANE_BITS] = {
                lane_in[gi].polarity_inv,
                lane_in[gi].remote_flush,
                lane_in[gi].lost_word,
                lane_in[gi].timeout,
                lane_in[gi].standby_word,
                lane_in[gi].rxerr_wrap && act,
                lane_in[gi].signal_lost && act,
                act
            };
            // active is a live level
            assign lane_sticky[gi*LANE_BITS+:LANE_BITS] = 8'hFE;
            assign rxerr_view[gi*RXERR_W+:RXERR_W] =
                lane_in[gi].receive_error_count;
        end
    endgenerate

    // broadcast sequence check
    wire [SEQ_W-1:0] bc_diff = bc_seq_in - bc_last_q;
    wire bc_missed = bc_seq_valid_in && bc_diff == 8'h02;
    wire bc_bad = bc_seq_valid_in && !bc_first_q && bc_diff != 8'h00
        && bc_diff != 8'h01 && bc_diff != 8'h02;

    assign bcq_set = {
        symbol_sync_in,
        retry_empty_in,
        crc8_seq_err_in,
        crc16_err_in,
        bc_bad,
        bc_missed
    };

    // sticky flags: set wins over a write-one clear
    always_ff @(posedge mclk_in or posedge reset_in) begin
        if (reset_in) begin
            vc_q <= '0;
            bcq_q <= '0;
            lane_q <= '0;
        end else if (status_clr) begin
            vc_q <= '0;
            bcq_q <= '0;
            lane_q <= '0;
        end else begin
            vc_q <= (vc_q & ~(wr_vc ? wdata_in[VCW-1:0] : '0)) | vc_set;
            bcq_q <= (bcq_q & ~(wr_bcq ? wdata_in[BCQ_BITS-1:0] : '0)) | bcq_set;
            lane_q <= (lane_q & ~(wr_lane ? wdata_in[LNW-1:0] : '0)) | lane_set;
        end
    end

    assign vc_view = (vc_q & vc_sticky) | (vc_set & ~vc_sticky);
    assign lane_view = (lane_q & lane_sticky) | (lane_set & ~lane_sticky);
    assign bcq_view = {bcq_q[BCQ_SYNC], retry_empty_in, bcq_q[BCQ_CRC8:0]};

    always_ff @(posedge mclk_in or posedge reset_in) begin
        if (reset_in) begin
            retry_cnt_q <= '0;
        end else if (status_clr) begin
            retry_cnt_q <= '0;
        end else if (retry_start_in) begin
            retry_cnt_q <= retry_cnt_q + 16'h0001;
        end
    end

    // last sequence survives warm reset; first-value guard only re-arms on cold
    always_ff @(posedge mclk_in or posedge reset_in) begin
        if (reset_in) begin
            bc_last_q <= '0;
            bc_first_q <= 1'b1;
        end else if (cold_reset_in) begin
            bc_last_q <= '0;
            bc_first_q <= 1'b1;
        end else if (bc_seq_valid_in) begin
            bc_last_q <= bc_seq_in;
            bc_first_q <= 1'b0;
        end
    end

    // reset side effects, one cycle pulses
    always_ff @(posedge mclk_in or posedge reset_in) begin
        if (reset_in) begin
            cold_clear_out <= 1'b1;
            credit_zero_out <= 1'b1;
            pll_reset_out <= 1'b1;
        end else begin
            cold_clear_out <= cold_reset_in;
            credit_zero_out <= any_reset;
            pll_reset_out <= any_reset;
        end
    end

    // settings kept through warm reset
    generate
        for (gi = 0; gi < NUM_VC; gi++) begin : g_cfg
            localparam logic [BW_W-1:0] BW_INIT = gi == 0 ? BW0_RESET : BW_RESET;
            always_ff @(posedge mclk_in or posedge reset_in) begin
                if (reset_in) begin
                    priority_out[gi*PRIO_W+:PRIO_W] <= PRIO_RESET;
                    bandwidth_out[gi*BW_W+:BW_W] <= BW_INIT;
                    slots_out[gi*SLOT_W+:SLOT_W] <= SLOT_RESET;
                end else if (cold_reset_in) begin
                    priority_out[gi*PRIO_W+:PRIO_W] <= PRIO_RESET;
                    bandwidth_out[gi*BW_W+:BW_W] <= BW_INIT;
                    slots_out[gi*SLOT_W+:SLOT_W] <= SLOT_RESET;
                end else begin
                    if (wr_prio) begin
                        priority_out[gi*PRIO_W+:PRIO_W] <= wdata_in[gi*PRIO_W+:PRIO_W];
                    end
                    if (wr_bw) begin
                        bandwidth_out[gi*BW_W+:BW_W] <= wdata_in[gi*BW_W+:BW_W];
                    end
                    if (wr_slots) begin
                        slots_out[gi*SLOT_W+:SLOT_W] <= wdata_in[gi*SLOT_W+:SLOT_W];
                    end
                end
            end
        end
    endgenerate

    always_ff @(posedge mclk_in or posedge reset_in) begin
        if (reset_in) begin
            idle_limit_q <= IDLE_LIMIT;
            required_lanes_out <= REQ_LANES_RESET;
            seed_out <= SEED_RESET;
            start_mode_out <= '0;
            autostart_out <= '1;
        end else if (cold_reset_in) begin
            idle_limit_q <= IDLE_LIMIT;
            required_lanes_out <= REQ_LANES_RESET;
            seed_out <= SEED_RESET;
            start_mode_out <= '0;
            autostart_out <= '1;
        end else begin
            if (wr_idle) begin
                idle_limit_q <= wdata_in;
            end
            if (wr_seed) begin
                seed_out <= wdata_in;
            end
            if (wr_ctl) begin
                start_mode_out <= wdata_in[NUM_LANE-1:0];
                autostart_out <= wdata_in[CTL_AUTO_POS+:NUM_LANE];
                required_lanes_out <= wdata_in[CTL_REQ_POS+:4];
            end
        end
    end

    // cleared by both resets
    always_ff @(posedge mclk_in or posedge reset_in) begin
        if (reset_in) begin
            bit_invert_out <= '0;
            dist_lane_out <= '0;
            conc_lane_out <= '0;
        end else if (any_reset) begin
            bit_invert_out <= '0;
            dist_lane_out <= '0;
            conc_lane_out <= '0;
        end else begin
            if (wr_ctl) begin
                bit_invert_out <= wdata_in[CTL_INV_POS+:NUM_LANE];
            end
            if (wr_lnum) begin
                dist_lane_out <= wdata_in[LNUM_W-1:0];
                conc_lane_out <= wdata_in[LNUM_W+:LNUM_W];
            end
        end
    end

    // read mux
    assign lane_ctl_view = 32'({required_lanes_out, 4'h0,
        (4)'(bit_invert_out), (4)'(autostart_out), (4)'(start_mode_out)});

    logic [31:0] rd_mux;
    always_comb begin
        unique case (addr_in)
            ADDR_VC_STAT: rd_mux = 32'(vc_view);
            ADDR_BCQ_STAT: rd_mux = 32'(bcq_view);
            ADDR_RETRY_CNT: rd_mux = 32'(retry_cnt_q);
            ADDR_LANE_STAT: rd_mux = 32'(lane_view);
            ADDR_RXERR: rd_mux = 32'(rxerr_view);
            ADDR_PRIO: rd_mux = 32'(priority_out);
            ADDR_BW: rd_mux = 32'(bandwidth_out);
            ADDR_SLOTS: rd_mux = 32'(slots_out);
            ADDR_IDLE: rd_mux = idle_limit_q;
            ADDR_LANE_CTL: rd_mux = lane_ctl_view;
            ADDR_SEED: rd_mux = seed_out;
            ADDR_LANE_NUM: rd_mux = 32'({conc_lane_out, dist_lane_out});
            default: rd_mux = '0;
        endcase
    end

    // data only in the cycle after the strobe
    always_ff @(posedge mclk_in or posedge reset_in) begin
        if (reset_in) begin
            rdata_out <= '0;
        end else begin
            rdata_out <= rd_in ? rd_mux : '0;
        end
    end
endmodule : link_status_regs

/* inc/link_status_pkg.sv */
package link_status_pkg;
    // register byte addresses
    localparam logic [7:0] ADDR_VC_STAT = 8'h00;
    localparam logic [7:0] ADDR_BCQ_STAT = 8'h04;
    localparam logic [7:0] ADDR_RETRY_CNT = 8'h08;
    localparam logic [7:0] ADDR_LANE_STAT = 8'h0C;
    localparam logic [7:0] ADDR_RXERR = 8'h10;
    localparam logic [7:0] ADDR_PRIO = 8'h14;
    localparam logic [7:0] ADDR_BW = 8'h18;
    localparam logic [7:0] ADDR_SLOTS = 8'h1C;
    localparam logic [7:0] ADDR_IDLE = 8'h20;
    localparam logic [7:0] ADDR_LANE_CTL = 8'h24;
    localparam logic [7:0] ADDR_SEED = 8'h28;
    localparam logic [7:0] ADDR_LANE_NUM = 8'h2C;
    // field layout
    localparam int VC_BITS = 4;
    localparam int VC_OVERUSE = 0;
    localparam int VC_UNDERUSE = 1;
    localparam int VC_CREDIT = 2;
    localparam int VC_OVERFLOW = 3;
    localparam int LANE_BITS = 8;
    localparam int BCQ_MISSED = 0;
    localparam int BCQ_SEQERR = 1;
    localparam int BCQ_CRC16 = 2;
    localparam int BCQ_CRC8 = 3;
    localparam int BCQ_RETRY_EMPTY = 4;
    localparam int BCQ_SYNC = 5;
    localparam int BCQ_BITS = 6;
    localparam int CTL_AUTO_POS = 4;
    localparam int CTL_INV_POS = 8;
    localparam int CTL_REQ_POS = 12;
    // widths
    localparam int CREDIT_W = 8;
    localparam int SEQ_W = 8;
    localparam int RXERR_W = 8;
    localparam int RETRY_W = 16;
    localparam int PRIO_W = 4;
    localparam int BW_W = 8;
    localparam int SLOT_W = 8;
    localparam int LNUM_W = 8;
    // reset values
    localparam logic [PRIO_W-1:0] PRIO_RESET = 4'hF;
    localparam logic [BW_W-1:0] BW0_RESET = 8'h0A;
    localparam logic [BW_W-1:0] BW_RESET = 8'h00;
    localparam logic [SLOT_W-1:0] SLOT_RESET = 8'hFF;
    localparam logic [3:0] REQ_LANES_RESET = 4'h1;
    localparam logic [31:0] SEED_RESET = 32'hFFFF_FFFF;
    localparam logic [CREDIT_W-1:0] CREDIT_MIN = 8'h00;
    localparam logic [CREDIT_W-1:0] CREDIT_MAX = 8'hFF;
    // timing
    localparam int CLK_MHZ = 100;
    localparam int IDLE_LIMIT_US = 1000;
    localparam int IDLE_CYCLES = IDLE_LIMIT_US * CLK_MHZ;

    typedef struct packed {
        logic [CREDIT_W-1:0] credit;
        logic far_space;
        logic write_when_full;
    } vc_report_type;

    typedef struct packed {
        logic active;
        logic signal_lost;
        logic rxerr_wrap;
        logic [RXERR_W-1:0] receive_error_count;
        logic standby_word;
        logic lost_word;
        logic remote_flush;
        logic timeout;
        logic polarity_inv;
    } lane_report_type;
endpackage : link_status_pkg

/* tb/link_status_regs_asserts.sv */
`timescale 1ns/100ps
module link_status_regs_asserts
    import link_status_pkg::*;
#(
    parameter int NUM_VC = 4,
    parameter int NUM_LANE = 4
) (
    // clock and resets
    input wire logic mclk_in,
    input wire logic reset_in,
    input wire logic cold_reset_in,
    input wire logic warm_reset_in,
    // register port and events
    input wire logic [7:0] addr_in,
    input wire logic wr_in,
    input wire logic rd_in,
    input wire logic retry_start_in,
    input wire logic [31:0] rdata_out,
    // reset effects and settings
    input wire logic cold_clear_out,
    input wire logic credit_zero_out,
    input wire logic pll_reset_out,
    input wire logic [NUM_VC*PRIO_W-1:0] priority_out,
    input wire logic [NUM_LANE-1:0] bit_invert_out,
    input wire logic [3:0] required_lanes_out,
    input wire logic [31:0] seed_out,
    input wire logic [LNUM_W-1:0] dist_lane_out,
    input wire logic [LNUM_W-1:0] conc_lane_out
);
    default clocking cb @(posedge mclk_in);
    endclocking
    default disable iff (reset_in);
    sequence s_any_rst;
        cold_reset_in || warm_reset_in;
    endsequence
    sequence s_retry_rd;
        rd_in && addr_in == ADDR_RETRY_CNT;
    endsequence
    AST_COLD_CLEAR: assert property (cold_reset_in |=> cold_clear_out)
        else $error("cold clear pulse missing");
    AST_PLL_CREDIT: assert property (s_any_rst |=> credit_zero_out && pll_reset_out)
        else $error("credit or pll pulse missing");
    AST_NO_PULSE: assert property (
        !reset_in && !cold_reset_in && !warm_reset_in
        |=> !cold_clear_out && !credit_zero_out && !pll_reset_out)
        else $error("reset effect pulse without request");
    AST_WARM_ONLY: assert property (warm_reset_in && !cold_reset_in |=> !cold_clear_out)
        else $error("warm reset flushed buffers");
    AST_COLD_DEFAULTS: assert property (cold_reset_in |=> priority_out == {NUM_VC{PRIO_RESET}}
        && seed_out == SEED_RESET && required_lanes_out == REQ_LANES_RESET)
        else $error("cold defaults not loaded");
    AST_WARM_CLEAR: assert property (warm_reset_in |=> bit_invert_out == '0
        && dist_lane_out == '0 && conc_lane_out == '0)
        else $error("warm reset left inversion or lane numbers");
    AST_WARM_KEEP: assert property (warm_reset_in && !cold_reset_in && !wr_in
        |=> $stable(seed_out) && $stable(priority_out))
        else $error("warm reset changed settings");
    AST_RETRY_CLR: assert property (
        s_any_rst ##1 !retry_start_in ##1 s_retry_rd |=> rdata_out == '0)
        else $error("retry count survived reset");
endmodule : link_status_regs_asserts

bind link_status_regs link_status_regs_asserts #(.NUM_VC(NUM_VC), .NUM_LANE(NUM_LANE)) i_asserts (
    .mclk_in(mclk_in), .reset_in(reset_in), .cold_reset_in(cold_reset_in),
    .warm_reset_in(warm_reset_in), .addr_in(addr_in), .wr_in(wr_in), .rd_in(rd_in),
    .retry_start_in(retry_start_in), .rdata_out(rdata_out), .cold_clear_out(cold_clear_out),
    .credit_zero_out(credit_zero_out), .pll_reset_out(pll_reset_out),
    .priority_out(priority_out), .bit_invert_out(bit_invert_out),
    .required_lanes_out(required_lanes_out), .seed_out(seed_out),
    .dist_lane_out(dist_lane_out), .conc_lane_out(conc_lane_out)
);

/* tb/tb.sv */
`timescale 1ns/100ps
module tb;
    import link_status_pkg::*;
    localparam int NV = 4;
    localparam int NL = 4;
    logic mclk_in, reset_in, cold_reset_in, warm_reset_in, wr_in, rd_in;
    logic [7:0] addr_in;
    logic [31:0] wdata_in, rdata_out, seed_out, v;
    vc_report_type [NV-1:0] vc_in;
    lane_report_type [NL-1:0] lane_in;
    logic [SEQ_W-1:0] bc_seq_in;
    logic bc_seq_valid_in, crc16_err_in, crc8_seq_err_in, retry_empty_in, retry_start_in;
    logic symbol_sync_in, cold_clear_out, credit_zero_out, pll_reset_out;
    logic [NV*PRIO_W-1:0] priority_out;
    logic [NV*BW_W-1:0] bandwidth_out;
    logic [NV*SLOT_W-1:0] slots_out;
    logic [NL-1:0] start_mode_out, autostart_out, bit_invert_out;
    logic [3:0] required_lanes_out;
    logic [LNUM_W-1:0] dist_lane_out, conc_lane_out;
    logic [7:0] rx[NL];
    int miscompares, total_checks, cycles, exp_retry, exp_bcq, last, first, r, d, n;
    int seqq[$];
    // short idle limit keeps the underuse wait at twenty cycles
    link_status_regs #(.NUM_VC(NV), .NUM_LANE(NL), .IDLE_LIMIT(32'h0000_0014)) i_dut (
        .mclk_in(mclk_in), .reset_in(reset_in), .cold_reset_in(cold_reset_in),
        .warm_reset_in(warm_reset_in), .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in),
        .rd_in(rd_in), .rdata_out(rdata_out), .vc_in(vc_in), .bc_seq_in(bc_seq_in),
        .bc_seq_valid_in(bc_seq_valid_in), .crc16_err_in(crc16_err_in),
        .crc8_seq_err_in(crc8_seq_err_in), .retry_empty_in(retry_empty_in),
        .retry_start_in(retry_start_in), .lane_in(lane_in), .symbol_sync_in(symbol_sync_in),
        .cold_clear_out(cold_clear_out), .credit_zero_out(credit_zero_out),
        .pll_reset_out(pll_reset_out), .priority_out(priority_out),
        .bandwidth_out(bandwidth_out), .slots_out(slots_out), .start_mode_out(start_mode_out),
        .autostart_out(autostart_out), .bit_invert_out(bit_invert_out),
        .required_lanes_out(required_lanes_out), .seed_out(seed_out),
        .dist_lane_out(dist_lane_out), .conc_lane_out(conc_lane_out)
    );
    initial begin
        mclk_in = 1'b0;
        forever #5 mclk_in = ~mclk_in;
    end
    always @(posedge mclk_in) begin
        cycles++;
        if (cycles == 5000) begin
            miscompares++;
            summarize();
        end
    end
    task automatic summarize();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : summarize
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic tick(input int k);
        repeat (k) @(posedge mclk_in);
    endtask : tick
    task automatic wr(input logic [7:0] a, input logic [31:0] wd);
        @(posedge mclk_in);
        addr_in <= a;
        wdata_in <= wd;
        wr_in <= 1'b1;
        @(posedge mclk_in);
        wr_in <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a);
        @(posedge mclk_in);
        addr_in <= a;
        rd_in <= 1'b1;
        @(posedge mclk_in);
        rd_in <= 1'b0;
        #1 v = rdata_out;
    endtask : rd
    task automatic pulse_rst(input logic cold);
        @(posedge mclk_in);
        cold_reset_in <= cold;
        warm_reset_in <= ~cold;
        @(posedge mclk_in);
        {cold_reset_in, warm_reset_in} <= 2'b00;
    endtask : pulse_rst
    task automatic chk_defaults();
        check("prio", priority_out, {NV{PRIO_RESET}});
        check("bw", bandwidth_out, {{(NV-1){BW_RESET}}, BW0_RESET});
        check("slots", slots_out, {NV{SLOT_RESET}});
        check("ctl", {required_lanes_out, bit_invert_out, autostart_out}, 12'h10F);
        check("start", start_mode_out, 0);
        check("seed", seed_out, SEED_RESET);
        check("lnum", {conc_lane_out, dist_lane_out}, 0);
    endtask : chk_defaults
    initial begin
        reset_in = 1'b1;
        {cold_reset_in, warm_reset_in, wr_in, rd_in, bc_seq_valid_in, retry_start_in} = '0;
        {crc16_err_in, crc8_seq_err_in, symbol_sync_in, addr_in, wdata_in, bc_seq_in} = '0;
        retry_empty_in = 1'b1;
        lane_in = '0;
        foreach (vc_in[i]) vc_in[i] = {8'h80, 2'b00};
        void'($urandom(32'h75ac5aa2));
        tick(4);
        reset_in <= 1'b0;
        chk_defaults();
        foreach (seqq[i]) seqq.delete();
        rd(ADDR_VC_STAT);
        check("vc0", v, 0);
        rd(ADDR_LANE_STAT);
        check("lane0", v, 0);
        rd(8'h3C);
        check("unmapped", v, 0);
        $display("test defaults done");
        n = $urandom_range(9, 1);
        repeat (n) begin
            @(posedge mclk_in);
            retry_start_in <= 1'b1;
            @(posedge mclk_in);
            retry_start_in <= 1'b0;
            exp_retry++;
        end
        rd(ADDR_RETRY_CNT);
        check("retry", v, exp_retry);
        pulse_rst(1'b0);
        exp_retry = 0;
        rd(ADDR_RETRY_CNT);
        check("retry_clr", v, exp_retry);
        $display("test retry done");
        pulse_rst(1'b1);
        first = 1;
        r = $urandom_range(200, 3);
        seqq = '{r, r + 1, r + 3, r + 8};
        foreach (seqq[i]) begin
            @(posedge mclk_in);
            bc_seq_in <= seqq[i][7:0];
            bc_seq_valid_in <= 1'b1;
            d = (seqq[i] - last) & 255;
            if (d == 2) exp_bcq |= 1;
            else if (d > 2 && first == 0) exp_bcq |= 2;
            first = 0;
            last = seqq[i];
        end
        @(posedge mclk_in);
        bc_seq_valid_in <= 1'b0;
        rd(ADDR_BCQ_STAT);
        check("bcast", v, exp_bcq | 32'h10);
        wr(ADDR_BCQ_STAT, 32'h0000_0003);
        rd(ADDR_BCQ_STAT);
        check("bcast_clr", v, 32'h0000_0010);
        $display("test broadcast done");
        @(posedge mclk_in);
        {crc16_err_in, crc8_seq_err_in, symbol_sync_in, retry_empty_in} <= 4'b1110;
        @(posedge mclk_in);
        {crc16_err_in, crc8_seq_err_in, symbol_sync_in} <= 3'b000;
        tick(3);
        rd(ADDR_BCQ_STAT);
        check("quality", v, 32'h0000_002C);
        $display("test quality done");
        @(posedge mclk_in);
        vc_in[0].credit <= CREDIT_MAX;
        tick(3);
        rd(ADDR_VC_STAT);
        check("vc_early", v, 0);
        @(posedge mclk_in);
        vc_in[1].credit <= CREDIT_MIN;
        vc_in[2].far_space <= 1'b1;
        vc_in[3].write_when_full <= 1'b1;
        @(posedge mclk_in);
        vc_in[1].credit <= 8'h80;
        vc_in[3].write_when_full <= 1'b0;
        tick(20);
        vc_in[0].credit <= 8'h80;
        rd(ADDR_VC_STAT);
        check("vc", v, 32'h0000_8412);
        $display("test channels done");
        foreach (rx[i]) rx[i] = 8'($urandom);
        @(posedge mclk_in);
        lane_in[0] <= {3'b111, rx[0], 5'b00000};
        lane_in[1] <= {3'b011, rx[1], 5'b00000};
        lane_in[2] <= {3'b000, rx[2], 5'b10010};
        lane_in[3] <= {3'b000, rx[3], 5'b01101};
        @(posedge mclk_in);
        foreach (lane_in[i]) lane_in[i] <= {i == 0, 2'b00, rx[i], 5'b00000};
        tick(2);
        rd(ADDR_LANE_STAT);
        check("lanes", v, 32'hE018_0007);
        rd(ADDR_RXERR);
        check("rxerr", v, {rx[3], rx[2], rx[1], rx[0]});
        $display("test lanes done");
        wr(ADDR_PRIO, 32'h0000_1234);
        wr(ADDR_LANE_CTL, 32'h0000_3F03);
        wr(ADDR_LANE_NUM, 32'h0000_0201);
        #1 check("inv_set", bit_invert_out, 4'hF);
        pulse_rst(1'b0);
        #1 check("prio_kept", priority_out, 16'h1234);
        check("ctl_warm", {required_lanes_out, bit_invert_out, start_mode_out}, 12'h303);
        check("lnum_warm", {conc_lane_out, dist_lane_out}, 0);
        rd(ADDR_LANE_STAT);
        check("lanes_clr", v, 32'h0000_0001);
        pulse_rst(1'b1);
        #1 chk_defaults();
        $display("test resets done");
        summarize();
    end
endmodule : tb
